// *** logic/swm_wear_monitor.sv ***
// Switchgear wear monitor: counts, current sums, capacity, travel and curve alarms
//
// Behaviour
// - Count switching operations, readable as statistic
// - Alarm when operation count exceeds limit
// - Accumulate interrupted current per phase
// - Current sum over limit: general plus phase alarms
// - Keep open capacity percent; 100 means maintenance
// - Slow flag when travel time exceeds limit
// - Hourly alarm when hour sum exceeds limit
// - Wear curve holds up to ten points
// - Last used point counts as zero operations
// - Interpolate allowed operations between curve points
// - Current beyond last point allows zero operations
// - Wear curve alarm from curve evaluation
`timescale 1ns/1ps
module swm_wear_monitor import swm_pkg::*; #(
    parameter longint MINUTE_CYC = MINUTE_CYCLES
) (
    input  wire logic              clk_in,
    input  wire logic              rst_b_in,
    input  wire logic              trip_in,
    input  wire logic [CUR_W-1:0]  cur_ph1_in,
    input  wire logic [CUR_W-1:0]  cur_ph2_in,
    input  wire logic [CUR_W-1:0]  cur_ph3_in,
    input  wire logic              clear_stats_in,
    input  wire logic [CNT_W-1:0]  op_limit_in,
    input  wire logic [SUM_W-1:0]  isum_limit_in,
    input  wire logic [SUM_W-1:0]  isum_hour_limit_in,
    input  wire logic              close_done_in,
    input  wire logic              open_done_in,
    input  wire logic [TIME_W-1:0] travel_time_in,
    input  wire logic [TIME_W-1:0] close_time_limit_in,
    input  wire logic [TIME_W-1:0] open_time_limit_in,
    input  wire logic [PTS_W-1:0]  curve_used_in,
    input  wire logic [KA_W-1:0]   curve_ka_in [PTS_MAX],
    input  wire logic [CNT_W-1:0]  curve_ops_in [PTS_MAX],
    output logic [CNT_W-1:0]       operation_count_out,
    output logic [SUM_W-1:0]       interrupted_sum_phase1_out,
    output logic [SUM_W-1:0]       interrupted_sum_phase2_out,
    output logic [SUM_W-1:0]       interrupted_sum_phase3_out,
    output logic [SUM_W-1:0]       hour_sum_out,
    output logic [PCT_W-1:0]       open_capacity_percent_out,
    output logic                   operations_alarm_out,
    output logic                   isum_alarm_out,
    output logic [2:0]             isum_phase_alarm_out,
    output logic                   hourly_interruption_alarm_out,
    output logic                   slow_operation_flag_out,
    output logic                   wear_curve_alarm_out
);
    ////////////////////////////////////////////////////////////////////////////////
    // Wear curve evaluation
    // Allowed operations for a current in amperes; last used point counts zero
    function automatic logic [CNT_W-1:0] curve_allowed(input logic [CUR_W-1:0] amps,
            input logic [PTS_W-1:0] used, input logic [KA_W-1:0] ka [PTS_MAX],
            input logic [CNT_W-1:0] ops [PTS_MAX]);
        logic [SUM_W-1:0] lo_a;
        logic [SUM_W-1:0] hi_a;
        logic [CNT_W-1:0] lo_o;
        logic [CNT_W-1:0] hi_o;
        logic [47:0]      span;
        logic [CNT_W-1:0] res;
        res = '0;
        if (used != '0 && {16'h0000, amps} < {24'h00_0000, ka[0]} * AMP_PER_KA) begin
            res = (used == 4'h1) ? '0 : ops[0];
        end
        for (int k = PTS_MAX - 2; k >= 0; k--) begin
            lo_a = {24'h00_0000, ka[k]} * AMP_PER_KA;
            hi_a = {24'h00_0000, ka[k+1]} * AMP_PER_KA;
            lo_o = ops[k];
            hi_o = (PTS_W'(k + 2) == used) ? '0 : ops[k+1];
            if (PTS_W'(k + 1) < used && {16'h0000, amps} >= lo_a
                    && {16'h0000, amps} <= hi_a) begin
                if (hi_a == lo_a || lo_o <= hi_o) begin
                    res = hi_o;
                end else begin
                    span = 48'(lo_o - hi_o) * 48'({16'h0000, amps} - lo_a);
                    res  = lo_o - CNT_W'(span / 48'(hi_a - lo_a));
                end
            end
        end
        return res;                                                  // zero beyond last
    endfunction

    logic [CUR_W-1:0] imax_w;
    logic [CNT_W-1:0] allowed_w;
    logic [SUM_W-1:0] wear_step_w;
    logic [SUM_W-1:0] trip_sum_w;

    always_comb begin
        imax_w = cur_ph1_in;
        if (cur_ph2_in > imax_w) imax_w = cur_ph2_in;
        if (cur_ph3_in > imax_w) imax_w = cur_ph3_in;
        allowed_w   = curve_allowed(imax_w, curve_used_in, curve_ka_in, curve_ops_in);
        wear_step_w = (allowed_w == '0) ? WEAR_FULL : WEAR_FULL / {8'h00, allowed_w};
        trip_sum_w  = SUM_W'(cur_ph1_in) + SUM_W'(cur_ph2_in) + SUM_W'(cur_ph3_in);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Minute divider and sliding hour window
    // One bucket per minute; the oldest is dropped as the window moves on
    logic [SUM_W-1:0] bucket_r [MIN_PER_HR];
    logic [BKT_W-1:0] bkt_idx_r, bkt_idx_nxt;
    logic [63:0]      min_cnt_r, min_cnt_nxt;
    logic [SUM_W-1:0] hour_r, hour_nxt;
    logic             tick_w;
    logic [BKT_W-1:0] bkt_new_w;

    always_comb begin
        tick_w      = (min_cnt_r == 64'(MINUTE_CYC - 1));
        min_cnt_nxt = tick_w ? '0 : min_cnt_r + 64'h0000_0000_0000_0001;
        bkt_new_w   = (bkt_idx_r == BKT_W'(MIN_PER_HR - 1)) ? '0 : bkt_idx_r + 6'h01;
        bkt_idx_nxt = tick_w ? bkt_new_w : bkt_idx_r;
        hour_nxt    = hour_r - (tick_w ? bucket_r[bkt_new_w] : '0)
                    + (trip_in ? trip_sum_w : '0);
        if (clear_stats_in) begin
            hour_nxt = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in || clear_stats_in) begin
            for (int i = 0; i < MIN_PER_HR; i++) bucket_r[i] <= '0;
        end else begin
            if (tick_w) begin
                bucket_r[bkt_new_w] <= trip_in ? trip_sum_w : '0;
            end else if (trip_in) begin
                bucket_r[bkt_idx_r] <= bucket_r[bkt_idx_r] + trip_sum_w;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            bkt_idx_r <= '0;
            min_cnt_r <= '0;
            hour_r    <= '0;
        end else begin
            bkt_idx_r <= bkt_idx_nxt;
            min_cnt_r <= min_cnt_nxt;
            hour_r    <= hour_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Statistics and alarms
    logic [CNT_W-1:0] ops_r, ops_nxt;
    logic [SUM_W-1:0] sum_r [3];
    logic [SUM_W-1:0] sum_nxt [3];
    logic [SUM_W-1:0] wear_r, wear_nxt;
    logic [PCT_W-1:0] pct_nxt;
    logic [2:0]       ph_alm_nxt;
    logic             slow_nxt;
    logic             slow_evt_w;
    logic [CUR_W-1:0] cur_w [3];

    always_comb begin
        cur_w[0] = cur_ph1_in;
        cur_w[1] = cur_ph2_in;
        cur_w[2] = cur_ph3_in;
        ops_nxt  = trip_in ? ops_r + 24'h00_0001 : ops_r;
        for (int p = 0; p < 3; p++) begin
            sum_nxt[p] = trip_in ? sum_r[p] + SUM_W'(cur_w[p]) : sum_r[p];
        end
        // Wear saturates at full so the percent can never wrap past 100
        wear_nxt = wear_r;
        if (trip_in) begin
            wear_nxt = (WEAR_FULL - wear_r <= wear_step_w) ? WEAR_FULL : wear_r + wear_step_w;
        end
        slow_evt_w = (close_done_in & (travel_time_in > close_time_limit_in))
                   | (open_done_in & (travel_time_in > open_time_limit_in));
        slow_nxt   = slow_operation_flag_out | slow_evt_w;
        if (clear_stats_in) begin
            ops_nxt  = '0;
            wear_nxt = '0;
            for (int p = 0; p < 3; p++) sum_nxt[p] = '0;
            // A slow travel seen in the clear cycle must not be lost
            slow_nxt = slow_evt_w;
        end
        pct_nxt = PCT_W'((64'(wear_r) * 64'(PCT_FULL)) / 64'(WEAR_FULL));
        for (int p = 0; p < 3; p++) begin
            ph_alm_nxt[p] = sum_r[p] > isum_limit_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            ops_r                         <= '0;
            for (int p = 0; p < 3; p++) sum_r[p] <= '0;
            wear_r                        <= '0;
            open_capacity_percent_out     <= '0;
            operations_alarm_out          <= 1'b0;
            isum_phase_alarm_out          <= '0;
            isum_alarm_out                <= 1'b0;
            hourly_interruption_alarm_out <= 1'b0;
            slow_operation_flag_out       <= 1'b0;
            wear_curve_alarm_out          <= 1'b0;
        end else begin
            ops_r                         <= ops_nxt;
            for (int p = 0; p < 3; p++) sum_r[p] <= sum_nxt[p];
            wear_r                        <= wear_nxt;
            open_capacity_percent_out     <= pct_nxt;
            operations_alarm_out          <= ops_r > op_limit_in;
            isum_phase_alarm_out          <= ph_alm_nxt;
            isum_alarm_out                <= |ph_alm_nxt;
            hourly_interruption_alarm_out <= hour_r > isum_hour_limit_in;
            slow_operation_flag_out       <= slow_nxt;
            wear_curve_alarm_out          <= wear_r >= WEAR_FULL;
        end
    end

    assign operation_count_out        = ops_r;
    assign interrupted_sum_phase1_out = sum_r[0];
    assign interrupted_sum_phase2_out = sum_r[1];
    assign interrupted_sum_phase3_out = sum_r[2];
    assign hour_sum_out               = hour_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    sequence trip_s;
        trip_in && !clear_stats_in;
    endsequence

    chk_op_count_step: assert property (trip_s |=> ops_r == $past(ops_r) + 24'h00_0001)
        else $error("operation count did not step on trip");
    chk_op_limit_alarm: assert property (
        ##1 (operations_alarm_out == $past(ops_r > op_limit_in)))
        else $error("operation alarm does not follow count against limit");
    chk_phase_sum_add: assert property (
        trip_s |=> sum_r[1] == $past(sum_r[1]) + SUM_W'($past(cur_ph2_in)))
        else $error("phase two sum did not accumulate");
    chk_isum_general_or: assert property (##1 isum_alarm_out ==
        ($past(sum_r[0] > isum_limit_in) || $past(sum_r[1] > isum_limit_in)
        || $past(sum_r[2] > isum_limit_in)))
        else $error("general current alarm does not follow phase sums");
    chk_capacity_full: assert property (
        wear_r >= WEAR_FULL |-> ##1 (open_capacity_percent_out == PCT_FULL && wear_curve_alarm_out))
        else $error("full wear not shown as 100 percent and alarm");
    chk_slow_close: assert property (
        close_done_in && !clear_stats_in && travel_time_in > close_time_limit_in
        |=> slow_operation_flag_out [*2])
        else $error("slow close not flagged and held");
    chk_hour_alarm: assert property (
        hour_r > isum_hour_limit_in ##1 hour_r > isum_hour_limit_in |-> hourly_interruption_alarm_out)
        else $error("hourly alarm missing while sum above limit");
    chk_beyond_last: assert property (
        curve_used_in != '0 && {16'h0000, imax_w} >
        {24'h00_0000, curve_ka_in[curve_used_in - 4'h1]} * AMP_PER_KA |-> allowed_w == '0)
        else $error("current beyond last point gave nonzero operations");
    chk_window_drop: assert property (
        tick_w && !trip_in && !clear_stats_in
        |=> hour_r == $past(hour_r) - $past(bucket_r[bkt_new_w]))
        else $error("oldest minute not removed from hour sum");
endmodule // swm_wear_monitor

// *** logic/swm_pkg.sv ***
// Shared constants for the switchgear wear monitor
package swm_pkg;
    localparam int CUR_W      = 16;   // Phase current magnitude, amperes
    localparam int KA_W       = 8;    // Curve point current, kiloamperes
    localparam int CNT_W      = 24;   // Operation counts
    localparam int SUM_W      = 32;   // Accumulated current sums
    localparam int TIME_W     = 16;   // Travel times
    localparam int PCT_W      = 7;    // Percent value
    localparam int PTS_MAX    = 10;   // Wear curve points
    localparam int PTS_W      = 4;
    localparam int MIN_PER_HR = 60;   // Sliding window buckets, one per minute
    localparam int BKT_W      = 6;
    localparam logic [PCT_W-1:0] PCT_FULL = 7'h64;              // 100 percent
    localparam logic [SUM_W-1:0] WEAR_FULL = 32'h000F_4240;     // Wear units at 100 percent
    localparam logic [SUM_W-1:0] AMP_PER_KA = 32'h0000_03E8;    // 1000 A per kA
    localparam longint CLK_HZ        = 100_000_000;
    localparam longint MINUTE_S      = 60;
    localparam longint MINUTE_CYCLES = MINUTE_S * CLK_HZ;
endpackage

// *** verification/swm_breaker_model.sv ***
// Breaker model: trip events with phase currents and travel-done pulses
`timescale 1ns/1ps
module swm_breaker_model import swm_pkg::*; (
    input  wire logic         clk_in,
    output logic              trip_out,
    output logic [CUR_W-1:0]  cur_ph1_out,
    output logic [CUR_W-1:0]  cur_ph2_out,
    output logic [CUR_W-1:0]  cur_ph3_out,
    output logic              close_done_out,
    output logic              open_done_out,
    output logic [TIME_W-1:0] travel_time_out
);
    initial begin
        {trip_out, close_done_out, open_done_out} = 3'h0;
        {cur_ph1_out, cur_ph2_out, cur_ph3_out, travel_time_out} = '0;
    end
    // Caller enters just after an edge; stale values are inverted so nothing leans on them
    task automatic trips(input int n, input logic [CUR_W-1:0] a, b, c);
        trip_out = 1'h1;
        {cur_ph1_out, cur_ph2_out, cur_ph3_out} = {a, b, c};
        repeat (n) @(posedge clk_in);
        #1;
        trip_out = 1'h0;
        {cur_ph1_out, cur_ph2_out, cur_ph3_out} = ~{a, b, c};
    endtask
    task automatic travel(input logic is_close, input logic [TIME_W-1:0] t);
        close_done_out = is_close;
        open_done_out = ~is_close;
        travel_time_out = t;
        @(posedge clk_in);
        #1;
        {close_done_out, open_done_out} = 2'h0;
        travel_time_out = ~t;
    endtask
endmodule // swm_breaker_model

// *** verification/tb_top.sv ***
// Self-checking testbench for the switchgear wear monitor
`timescale 1ns/1ps
module tb_top import swm_pkg::*; ;
    logic              clk_in = 1'h0;
    logic              rst_b_in, clear_stats_in, trip, close_done, open_done;
    logic [CUR_W-1:0]  c1, c2, c3;
    logic [TIME_W-1:0] tt, close_lim, open_lim;
    logic [CNT_W-1:0]  op_limit, op_cnt;
    logic [SUM_W-1:0]  isum_limit, hour_limit, s1, s2, s3, hsum;
    logic [PTS_W-1:0]  used;
    logic [KA_W-1:0]   ka [PTS_MAX];
    logic [CNT_W-1:0]  ops [PTS_MAX];
    logic [PCT_W-1:0]  pct;
    logic [2:0]        ph_alm;
    logic              op_alm, isum_alm, hr_alm, slow, wear_alm;
    int                num_errors = 0;
    int                compares = 0;
    int                k;
    int                c_used [4] = '{3, 3, 10, 3};
    int                c_all [4] = '{19, 9, 2, 0};
    logic [CUR_W-1:0]  c_cur [4] = '{16'h05DC, 16'h09C4, 16'h251C, 16'h0DAC};

    always #5 clk_in = ~clk_in;

    swm_breaker_model u_brk (.clk_in(clk_in), .trip_out(trip), .cur_ph1_out(c1),
        .cur_ph2_out(c2), .cur_ph3_out(c3), .close_done_out(close_done),
        .open_done_out(open_done), .travel_time_out(tt));

    // Short minute keeps the sixty-bucket window inside the run
    swm_wear_monitor #(.MINUTE_CYC(20)) u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .trip_in(trip), .cur_ph1_in(c1), .cur_ph2_in(c2), .cur_ph3_in(c3),
        .clear_stats_in(clear_stats_in), .op_limit_in(op_limit), .isum_limit_in(isum_limit),
        .isum_hour_limit_in(hour_limit), .close_done_in(close_done), .open_done_in(open_done),
        .travel_time_in(tt), .close_time_limit_in(close_lim), .open_time_limit_in(open_lim),
        .curve_used_in(used), .curve_ka_in(ka), .curve_ops_in(ops),
        .operation_count_out(op_cnt), .interrupted_sum_phase1_out(s1),
        .interrupted_sum_phase2_out(s2), .interrupted_sum_phase3_out(s3),
        .hour_sum_out(hsum), .open_capacity_percent_out(pct),
        .operations_alarm_out(op_alm), .isum_alarm_out(isum_alm),
        .isum_phase_alarm_out(ph_alm), .hourly_interruption_alarm_out(hr_alm),
        .slow_operation_flag_out(slow), .wear_curve_alarm_out(wear_alm));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (num_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk_num(input logic [SUM_W-1:0] got, input logic [SUM_W-1:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: value %0d, expected %0d", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic set_curve(input int n);
        used = PTS_W'(n);
        for (int i = 0; i < PTS_MAX; i++) begin
            ka[i] = KA_W'(i + 1);
            ops[i] = CNT_W'((10 - i) * 2);
        end
    endtask
    task automatic clear();
        clear_stats_in = 1'h1;
        cyc(1);
        clear_stats_in = 1'h0;
        cyc(1);
    endtask
    // Percent after n trips that each allow the given count; zero allowed wears out at once
    function automatic logic [SUM_W-1:0] pct_of(input int allowed, input int n);
        if (allowed == 0) return 32'h0000_0064;
        return SUM_W'(((1000000 / allowed) * n * 100) / 1000000);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_b_in, clear_stats_in} = 2'h0;
        op_limit = 24'h00_0003;
        isum_limit = 32'h0000_05DC;
        hour_limit = 32'h0000_0BB8;
        close_lim = 16'h0014;
        open_lim = 16'h000A;
        set_curve(10);
        cyc(20);
        rst_b_in = 1'h1;
        chk_num(op_cnt, 0);
        chk_num(pct, 0);
        u_brk.trips(3, 16'h01F4, 16'h00C8, 16'h0064);
        cyc(4);
        chk_num(op_cnt, 3);
        chk_flag(op_alm, 1'h0);
        chk_num(pct, pct_of(20, 3));
        u_brk.trips(1, 16'h01F4, 16'h00C8, 16'h0064);
        cyc(4);
        chk_num(op_cnt, 4);
        chk_flag(op_alm, 1'h1);
        chk_num(s1, 32'h0000_07D0);
        chk_num(s2, 32'h0000_0320);
        chk_num(s3, 32'h0000_0190);
        chk_flag(isum_alm, 1'h1);
        chk_num(ph_alm, 3'h1);
        chk_num(hsum, 32'h0000_0C80);
        chk_flag(hr_alm, 1'h1);
        chk_num(pct, pct_of(20, 4));
        chk_flag(wear_alm, 1'h0);
        op_limit = 24'h00_0004;
        cyc(3);
        chk_flag(op_alm, 1'h0);
        for (k = 0; k < 1300 && hsum !== '0; k++) cyc(1);
        chk_flag(k > 1100 && k < 1300, 1'h1);
        cyc(3);
        chk_flag(hr_alm, 1'h0);
        chk_num(s1, 32'h0000_07D0);
        u_brk.travel(1'h0, 16'h000A);
        cyc(2);
        u_brk.travel(1'h1, 16'h000F);
        cyc(2);
        chk_flag(slow, 1'h0);
        u_brk.travel(1'h0, 16'h000B);
        cyc(2);
        chk_flag(slow, 1'h1);
        clear();
        chk_num(op_cnt, 0);
        chk_flag(slow, 1'h0);
        u_brk.travel(1'h1, 16'h0015);
        cyc(2);
        chk_flag(slow, 1'h1);
        for (int i = 0; i < 4; i++) begin
            set_curve(c_used[i]);
            clear();
            u_brk.trips(1, 16'h0064, c_cur[i], 16'h0064);
            cyc(4);
            chk_num(pct, pct_of(c_all[i], 1));
        end
        chk_flag(wear_alm, 1'h1);
        give_verdict();
    end
endmodule // tb_top
